/* pkg/sfi_pkg.sv */
// Shared constants and types for the servo fault indicator block.
// Assumes a single 250 MHz clock domain; all users refer to names here.
package sfi_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Timing.
    localparam int CLK_KHZ = 250000;
    localparam int PERIOD_MS = 5000;
    localparam int SLOT_MS = 250;
    localparam longint PERIOD_CYC = longint'(PERIOD_MS) * CLK_KHZ;
    localparam longint SLOT_CYC = longint'(SLOT_MS) * CLK_KHZ;

    ////////////////////////////////////////////////////////////////////////
    // Blink counts per protection, and the idle code.
    localparam logic [2:0] BLINK_NONE = 3'h0;
    localparam logic [2:0] BLINK_OC = 3'h1;
    localparam logic [2:0] BLINK_OV = 3'h2;
    localparam logic [2:0] BLINK_PHASE = 3'h4;
    localparam logic [2:0] BLINK_ENC = 3'h5;
    localparam logic [2:0] BLINK_FE = 3'h7;
    localparam logic [3:0] SLOT_LAST = 4'hF;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets.
    localparam logic [7:0] REG_FAULT = 8'h00;
    localparam logic [7:0] REG_IRQ_STAT = 8'h04;
    localparam logic [7:0] REG_IRQ_MASK = 8'h08;
    localparam logic [7:0] REG_GEAR_TOP = 8'h0C;
    localparam logic [7:0] REG_GEAR_BOTTOM = 8'h10;
    localparam logic [7:0] REG_FE_LIMIT = 8'h14;
    localparam logic [7:0] REG_CMD_POS = 8'h18;
    localparam logic [7:0] REG_FB_POS = 8'h1C;
    localparam logic [7:0] REG_BLINK = 8'h20;

    // Reset values.
    localparam logic [15:0] GEAR_TOP_RST = 16'h0001;
    localparam logic [15:0] GEAR_BOTTOM_RST = 16'h0001;
    localparam logic [15:0] FE_LIMIT_RST = 16'h0FA0;
    localparam logic [4:0] MASK_RST = 5'h00;

    // AXI responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // Carriers.
    typedef struct packed {
        logic fe;
        logic enc;
        logic phase;
        logic ov;
        logic oc;
    } sfi_faults_t;

    typedef struct packed {
        logic enc;
        logic phase;
        logic ov;
        logic oc;
    } sfi_sense_t;

    typedef struct packed {
        logic step;
        logic dir;
        logic enable;
        logic enc_a;
        logic enc_b;
    } sfi_pins_t;

endpackage : sfi_pkg

/* rtl/sfi_top.sv */
// Servo fault supervision, indicator blinking, direction, gear scaling.
// Assumes pins and sense flags are asynchronous and an AXI4-Lite master.
//
// Contract
// - Show only the highest-priority active protection.
// - Over-current shows one blink per period.
// - Over-voltage shows two blinks per period.
// - Phase error shows four blinks per period.
// - Encoder error shows five blinks per period.
// - Following error at limit; seven blinks.
// - Priority: OC, OV, phase, encoder, following.
// - Direction high turns motor clockwise.
// - Gear-scale steps; four counts per encoder line.
`timescale 1ns/1ns
module sfi_top #(
    parameter longint PERIOD_CYC = sfi_pkg::PERIOD_CYC,
    parameter longint SLOT_CYC = sfi_pkg::SLOT_CYC
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Controller pins and protection sense flags.
    input wire sfi_pkg::sfi_pins_t pins,
    input wire sfi_pkg::sfi_sense_t sense,
    // Drive outputs.
    output logic red_led,
    output logic motor_dir_cw,
    output logic motion_enable,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // Functions.

    // Fixed priority, highest first.
    function automatic logic [2:0] pick_code(input sfi_pkg::sfi_faults_t f);
        logic [2:0] c;
        c = sfi_pkg::BLINK_NONE;
        if (f.oc) c = sfi_pkg::BLINK_OC;
        else if (f.ov) c = sfi_pkg::BLINK_OV;
        else if (f.phase) c = sfi_pkg::BLINK_PHASE;
        else if (f.enc) c = sfi_pkg::BLINK_ENC;
        else if (f.fe) c = sfi_pkg::BLINK_FE;
        return c;
    endfunction : pick_code

    // Quadrature delta from previous and current A/B: +1, -1 or 0.
    function automatic logic signed [1:0] quad_delta(input logic [1:0] p,
                                                     input logic [1:0] c);
        logic signed [1:0] d;
        d = 2'sh0;
        case ({p, c})
            4'h1, 4'h7, 4'hE, 4'h8: d = 2'sh1;
            4'h2, 4'hB, 4'hD, 4'h4: d = -2'sh1;
            default: d = 2'sh0;
        endcase
        return d;
    endfunction : quad_delta

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers; stage one feeds only stage two.
    logic [4:0] pin_s1, pin_s2, pin_s3;
    logic [3:0] sen_s1, sen_s2;
    always_ff @(posedge aclk) begin
        pin_s1 <= pins;
        pin_s2 <= pin_s1;
        pin_s3 <= pin_s2;
        sen_s1 <= sense;
        sen_s2 <= sen_s1;
    end
    sfi_pkg::sfi_pins_t pin_now, pin_old;
    sfi_pkg::sfi_sense_t sen_now;
    assign pin_now = pin_s2;
    assign pin_old = pin_s3;
    assign sen_now = sen_s2;

    ////////////////////////////////////////////////////////////////////////
    // Registers.
    logic [15:0] gear_top, gear_bottom, fe_limit;
    logic [4:0] irq_mask, irq_stat;
    sfi_pkg::sfi_faults_t fault_lat;
    logic signed [31:0] cmd_pos, fb_pos;
    logic [2:0] blink_code, shown;

    ////////////////////////////////////////////////////////////////////////
    // Position command and feedback.
    wire step_edge = pin_now.step & ~pin_old.step;
    wire run = pin_now.enable & (fault_lat == '0);
    wire signed [31:0] top_s = {16'h0000, gear_top};
    wire signed [31:0] bot_s = {16'h0000, gear_bottom};
    wire signed [1:0] qd = quad_delta({pin_old.enc_a, pin_old.enc_b},
                                      {pin_now.enc_a, pin_now.enc_b});
    // Both counters are in numerator-times-denominator units, so the
    // gear ratio needs no divider: a step adds top, a count adds bottom.
    wire signed [31:0] next_cmd = !(step_edge & run) ? cmd_pos :
                                  pin_now.dir ? cmd_pos + top_s :
                                  cmd_pos - top_s;
    wire signed [31:0] next_fb = qd == 2'sh1 ? fb_pos + bot_s :
                                 qd == -2'sh1 ? fb_pos - bot_s :
                                 fb_pos;
    wire signed [31:0] pos_err = cmd_pos - fb_pos;
    wire [31:0] err_mag = pos_err[31] ? 32'(-pos_err) : 32'(pos_err);
    wire [31:0] fe_bound = 32'(fe_limit) * 32'(gear_bottom);
    // A zero limit disables the following-error check.
    wire fe_hit = (fe_limit != 16'h0000) && (err_mag >= fe_bound);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_pos <= 32'sh0;
            fb_pos <= 32'sh0;
        end else begin
            cmd_pos <= next_cmd;
            fb_pos <= next_fb;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fault latch and drive outputs.
    sfi_pkg::sfi_faults_t fault_now, next_fault;
    assign fault_now = '{fe: fe_hit, enc: sen_now.enc, phase: sen_now.phase,
                         ov: sen_now.ov, oc: sen_now.oc};
    assign next_fault = fault_lat | fault_now;
    wire [4:0] fault_rise = next_fault & ~fault_lat;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_lat <= '0;
            motion_enable <= 1'b0;
            motor_dir_cw <= 1'b0;
            blink_code <= sfi_pkg::BLINK_NONE;
        end else begin
            fault_lat <= next_fault;
            motion_enable <= run;
            motor_dir_cw <= pin_now.dir;
            blink_code <= pick_code(fault_lat);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Indicator timing: a fixed period cut into equal on/off slots.
    logic [31:0] per_cnt, slot_cnt;
    logic [3:0] slot_idx;
    wire per_end = per_cnt == 32'(PERIOD_CYC - 1);
    wire slot_end = slot_cnt == 32'(SLOT_CYC - 1);
    // Slot pairs count blinks; even slots lit, while pairs remain.
    wire next_led = (slot_idx < {shown, 1'b0}) & ~slot_idx[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            per_cnt <= 32'h0000_0000;
            slot_cnt <= 32'h0000_0000;
            slot_idx <= 4'h0;
            shown <= sfi_pkg::BLINK_NONE;
            red_led <= 1'b0;
        end else begin
            red_led <= next_led;
            if (per_end) begin
                // The code is sampled only here, so a period never mixes.
                per_cnt <= 32'h0000_0000;
                slot_cnt <= 32'h0000_0000;
                slot_idx <= 4'h0;
                shown <= blink_code;
            end else begin
                per_cnt <= per_cnt + 32'h0000_0001;
                slot_cnt <= slot_end ? 32'h0000_0000 :
                            slot_cnt + 32'h0000_0001;
                if (slot_end && slot_idx != sfi_pkg::SLOT_LAST)
                    slot_idx <= slot_idx + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave.
    logic aw_got, w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    wire aw_hs = s_axi_awvalid & s_axi_awready;
    wire w_hs = s_axi_wvalid & s_axi_wready;
    wire do_write = aw_got & w_got & ~s_axi_bvalid;
    wire ar_hs = s_axi_arvalid & s_axi_arready;
    assign s_axi_awready = ~aw_got & ~s_axi_bvalid;
    assign s_axi_wready = ~w_got & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    wire wr_stat = do_write && aw_addr == sfi_pkg::REG_IRQ_STAT;
    wire wr_mask = do_write && aw_addr == sfi_pkg::REG_IRQ_MASK;
    wire wr_top = do_write && aw_addr == sfi_pkg::REG_GEAR_TOP;
    wire wr_bot = do_write && aw_addr == sfi_pkg::REG_GEAR_BOTTOM;
    wire wr_lim = do_write && aw_addr == sfi_pkg::REG_FE_LIMIT;
    wire wr_ro = do_write && (aw_addr == sfi_pkg::REG_FAULT ||
                 aw_addr == sfi_pkg::REG_CMD_POS ||
                 aw_addr == sfi_pkg::REG_FB_POS ||
                 aw_addr == sfi_pkg::REG_BLINK);
    wire wr_ok = wr_stat | wr_mask | wr_top | wr_bot | wr_lim | wr_ro;
    logic [3:0] w_strb;
    wire w_data_lane0 = w_strb[0];
    wire [4:0] stat_clr = wr_stat && w_data_lane0 ? w_data[4:0] : 5'h00;
    // Set wins over a clear in the same cycle.
    wire [4:0] next_stat = (irq_stat & ~stat_clr) | fault_rise;

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] be);
        return {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= sfi_pkg::RESP_OKAY;
        end else begin
            if (aw_hs) begin
                aw_got <= 1'b1;
                aw_addr <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (w_hs) begin
                w_got <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? sfi_pkg::RESP_OKAY
                                     : sfi_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat <= 5'h00;
            irq_mask <= sfi_pkg::MASK_RST;
            gear_top <= sfi_pkg::GEAR_TOP_RST;
            gear_bottom <= sfi_pkg::GEAR_BOTTOM_RST;
            fe_limit <= sfi_pkg::FE_LIMIT_RST;
            irq <= 1'b0;
        end else begin
            irq_stat <= next_stat;
            irq <= (next_stat & irq_mask) != 5'h00;
            if (wr_mask && w_data_lane0) irq_mask <= w_data[4:0];
            if (wr_top) gear_top <= merge16(gear_top, w_data, w_strb);
            if (wr_bot) gear_bottom <= merge16(gear_bottom, w_data, w_strb);
            if (wr_lim) fe_limit <= merge16(fe_limit, w_data, w_strb);
        end
    end

    wire [7:0] ar_word = {s_axi_araddr[7:2], 2'b00};
    logic [31:0] rd_mux;
    logic rd_ok;
    always_comb begin
        rd_ok = 1'b1;
        case (ar_word)
            sfi_pkg::REG_FAULT: rd_mux = {27'h0, fault_lat};
            sfi_pkg::REG_IRQ_STAT: rd_mux = {27'h0, irq_stat};
            sfi_pkg::REG_IRQ_MASK: rd_mux = {27'h0, irq_mask};
            sfi_pkg::REG_GEAR_TOP: rd_mux = {16'h0, gear_top};
            sfi_pkg::REG_GEAR_BOTTOM: rd_mux = {16'h0, gear_bottom};
            sfi_pkg::REG_FE_LIMIT: rd_mux = {16'h0, fe_limit};
            sfi_pkg::REG_CMD_POS: rd_mux = cmd_pos;
            sfi_pkg::REG_FB_POS: rd_mux = fb_pos;
            sfi_pkg::REG_BLINK: rd_mux = {29'h0, blink_code};
            default: begin
                rd_mux = 32'h0000_0000;
                rd_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= sfi_pkg::RESP_OKAY;
        end else if (ar_hs) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_ok ? sfi_pkg::RESP_OKAY
                                 : sfi_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_oc_top_prio: assert property (fault_lat.oc |=>
        blink_code == sfi_pkg::BLINK_OC) else $error("oc not shown");
    a_ov_code: assert property (fault_lat.ov && !fault_lat.oc |=>
        blink_code == sfi_pkg::BLINK_OV) else $error("ov code wrong");
    a_phase_code: assert property (fault_lat[2:0] == 3'b100 |=>
        blink_code == sfi_pkg::BLINK_PHASE) else $error("phase code wrong");
    a_enc_code: assert property (fault_lat[3:0] == 4'b1000 |=>
        blink_code == sfi_pkg::BLINK_ENC) else $error("enc code wrong");
    a_fe_latch: assert property (fe_hit |=> fault_lat.fe ##1
        blink_code == sfi_pkg::BLINK_FE || fault_lat[3:0] != 4'h0)
        else $error("following error not latched");
    a_oc_one_blink: assert property (shown == sfi_pkg::BLINK_OC &&
        slot_idx >= 4'h2 |=> !red_led) else $error("oc blinks too often");
    a_prio_order: assert property (fault_lat.ov && fault_lat.fe &&
        !fault_lat.oc |=> blink_code != sfi_pkg::BLINK_FE)
        else $error("priority order wrong");
    a_dir_follow: assert property (##1 motor_dir_cw ==
        $past(pin_now.dir)) else $error("direction not followed");
    sequence s_fwd_step;
        step_edge && run && pin_now.dir;
    endsequence
    a_gear_step: assert property (s_fwd_step |=>
        cmd_pos == $past(cmd_pos) + $past(top_s))
        else $error("step not scaled");
    a_led_dark: assert property (red_led |->
        $past(slot_idx) < {$past(shown), 1'b0}) else $error("led lit late");
    a_latch_hold: assert property (##1 (fault_lat & $past(fault_lat))
        == $past(fault_lat)) else $error("fault released");
    a_motion_stop: assert property (fault_lat != '0 |=>
        !motion_enable) else $error("motion not stopped");

endmodule : sfi_top

/* verification/sfi_ctl_model.sv */
// Step and direction motion controller model for the fault indicator bench.
// Assumes one free-running clock; the bench calls its tasks by hierarchy.
`timescale 1ns/1ns
module sfi_ctl_model #(
    parameter int SETUP_CYC = 1250,
    parameter int WIDTH_CYC = 625
) (
    // Clock.
    input wire logic aclk,
    // Controller outputs.
    output logic step,
    output logic dir,
    output logic enable
);

    initial begin
        step = 1'b0;
        dir = 1'b0;
        enable = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Enable is settled a full setup time before any direction change.
    task automatic power(input logic on);
        @(posedge aclk);
        enable <= on;
        repeat (SETUP_CYC) @(posedge aclk);
    endtask : power

    // The extra gap lets the bench play a slow controller.
    task automatic move(input int n, input logic d, input int extra);
        @(posedge aclk);
        dir <= d;
        repeat (SETUP_CYC + extra) @(posedge aclk);
        repeat (n) begin
            step <= 1'b1;
            repeat (WIDTH_CYC) @(posedge aclk);
            step <= 1'b0;
            repeat (WIDTH_CYC + extra) @(posedge aclk);
        end
    endtask : move

endmodule : sfi_ctl_model

/* verification/tb.sv */
// Self-checking bench for the servo fault indicator block.
// Assumes short blink periods set by parameter and a 250 MHz clock.
`timescale 1ns/1ns
module tb;
    localparam longint PER = 200;
    localparam longint SLOT = 10;
    logic aclk;
    logic aresetn;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic c_step, c_dir, c_en, enc_a, enc_b;
    logic red_led, motor_dir_cw, motion_enable, irq;
    sfi_pkg::sfi_pins_t pins;
    sfi_pkg::sfi_sense_t sense;
    int bad_count;
    int total_checks;

    assign pins = {c_step, c_dir, c_en, enc_a, enc_b};

    sfi_top #(.PERIOD_CYC(PER), .SLOT_CYC(SLOT)) sfi_top_i (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .pins(pins), .sense(sense),
        .red_led(red_led), .motor_dir_cw(motor_dir_cw),
        .motion_enable(motion_enable), .irq(irq)
    );

    sfi_ctl_model sfi_ctl_model_i (
        .aclk(aclk), .step(c_step), .dir(c_dir), .enable(c_en)
    );

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %0h want %0h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit aw_done;
        bit w_done;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        aw_done = 0;
        w_done = 0;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && s_axi_awready === 1'b1) begin
                aw_done = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready === 1'b1) begin
                w_done = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        @(posedge aclk);
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        while (s_axi_arready !== 1'b1) @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        @(posedge aclk);
        while (s_axi_rvalid !== 1'b1) @(posedge aclk);
        rd_data = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(rd_data, exp);
        chk({30'h0, rsp}, {30'h0, sfi_pkg::RESP_OKAY});
    endtask : rchk

    task automatic rst;
        sense <= '0;
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask : rst

    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        rchk(sfi_pkg::REG_GEAR_TOP, {16'h0, sfi_pkg::GEAR_TOP_RST});
        rchk(sfi_pkg::REG_GEAR_BOTTOM, {16'h0, sfi_pkg::GEAR_BOTTOM_RST});
        rchk(sfi_pkg::REG_FE_LIMIT, {16'h0, sfi_pkg::FE_LIMIT_RST});
        rchk(sfi_pkg::REG_IRQ_MASK, {27'h0, sfi_pkg::MASK_RST});
        rd(8'h40);
        chk({30'h0, rsp}, {30'h0, sfi_pkg::RESP_SLVERR});
        chk(rd_data, 32'h0);
        wr(8'h40, 32'h0000_0001);
        chk({30'h0, rsp}, {30'h0, sfi_pkg::RESP_SLVERR});
        wr(sfi_pkg::REG_FAULT, 32'h0000_001F);
        chk({30'h0, rsp}, {30'h0, sfi_pkg::RESP_OKAY});
        rchk(sfi_pkg::REG_FAULT, 32'h0);
        s_axi_wstrb <= 4'h2;
        wr(sfi_pkg::REG_FE_LIMIT, 32'h0000_1234);
        s_axi_wstrb <= 4'hF;
        rchk(sfi_pkg::REG_FE_LIMIT, 32'h0000_12A0);
    endtask : t_regs

    task automatic t_motion;
        logic [1:0] q[4];
        q = '{2'h2, 2'h3, 2'h1, 2'h0};
        sfi_ctl_model_i.power(1'b1);
        sfi_ctl_model_i.move(0, 1'b1, 0);
        chk({31'h0, motor_dir_cw}, 32'h1);
        chk({31'h0, motion_enable}, 32'h1);
        wr(sfi_pkg::REG_GEAR_TOP, 32'h0000_0003);
        sfi_ctl_model_i.move(3, 1'b1, 0);
        rchk(sfi_pkg::REG_CMD_POS, 32'h0000_0009);
        sfi_ctl_model_i.move(2, 1'b0, 40);
        chk({31'h0, motor_dir_cw}, 32'h0);
        rchk(sfi_pkg::REG_CMD_POS, 32'h0000_0003);
        wr(sfi_pkg::REG_GEAR_BOTTOM, 32'h0000_0002);
        for (int i = 0; i < 4; i++) begin
            @(posedge aclk);
            {enc_a, enc_b} <= q[i];
            repeat (5) @(posedge aclk);
        end
        rchk(sfi_pkg::REG_FB_POS, 32'hFFFF_FFF8);
    endtask : t_motion

    // Counts blinks and lit time over one full period in steady state.
    task automatic blink_chk(input logic [2:0] n);
        int rises;
        int lit;
        logic prev;
        repeat (2 * PER) @(posedge aclk);
        rises = 0;
        lit = 0;
        prev = red_led;
        repeat (PER) begin
            @(posedge aclk);
            if (red_led === 1'b1 && prev === 1'b0) rises++;
            if (red_led === 1'b1) lit++;
            prev = red_led;
        end
        chk(32'(rises), {29'h0, n});
        chk(32'(lit), 32'(n) * 32'(SLOT));
        rchk(sfi_pkg::REG_BLINK, {29'h0, n});
    endtask : blink_chk

    // The sense flag is withdrawn early so the display rests on the latch.
    task automatic t_blink(input logic [3:0] s, input logic [2:0] n);
        rst();
        sense <= s;
        repeat (20) @(posedge aclk);
        sense <= '0;
        blink_chk(n);
    endtask : t_blink

    task automatic t_irq;
        rst();
        sense <= 4'h2;
        repeat (10) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        rchk(sfi_pkg::REG_IRQ_STAT, 32'h0000_0002);
        wr(sfi_pkg::REG_IRQ_MASK, 32'h0000_001F);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h1);
        wr(sfi_pkg::REG_IRQ_STAT, 32'h0000_0002);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        rchk(sfi_pkg::REG_FAULT, 32'h0000_0002);
    endtask : t_irq

    task automatic t_fe;
        rst();
        wr(sfi_pkg::REG_FE_LIMIT, 32'h0000_0002);
        sfi_ctl_model_i.move(2, 1'b1, 0);
        rchk(sfi_pkg::REG_FAULT, 32'h0000_0010);
        chk({31'h0, motion_enable}, 32'h0);
        sfi_ctl_model_i.move(3, 1'b1, 0);
        rchk(sfi_pkg::REG_CMD_POS, 32'h0000_0002);
        blink_chk(sfi_pkg::BLINK_FE);
        sense <= 4'h2;
        blink_chk(sfi_pkg::BLINK_OV);
    endtask : t_fe

    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test

    initial begin
        repeat (60000) @(posedge aclk);
        bad_count++;
        $display("[ERR] %0t watchdog expired", $time);
        finish_test();
    end

    initial begin
        aresetn = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        sense = '0;
        {enc_a, enc_b} = 2'h0;
        bad_count = 0;
        total_checks = 0;
        rst();
        t_regs();
        t_motion();
        t_irq();
        t_blink(4'h1, sfi_pkg::BLINK_OC);
        t_blink(4'h2, sfi_pkg::BLINK_OV);
        t_blink(4'h4, sfi_pkg::BLINK_PHASE);
        t_blink(4'h8, sfi_pkg::BLINK_ENC);
        t_blink(4'hF, sfi_pkg::BLINK_OC);
        t_blink(4'hA, sfi_pkg::BLINK_OV);
        t_blink(4'hC, sfi_pkg::BLINK_PHASE);
        t_fe();
        finish_test();
    end

endmodule : tb
